// ### rtl/risc_operand_decoder.sv
// Instruction decoder: opcode, addressing form and operand sizing
`timescale 1ns/1ns
//
// Contract
// RULE1 - Register indirect only for load, store, input
// RULE2 - Field codes map registers; 10111, 11111 reserved
// RULE3 - Stack pointer indirect only for pop, push
// RULE4 - Absolute uses second word; load/store/in/out
// RULE5 - Literal to word destination sign-extends
// RULE6 - Long source to word keeps low half
// RULE7 - Equal widths pass unchanged
// RULE8 - Long destination sign-extends literal and word
// RULE9 - Byte instructions write eight bits only
// RULE10 - Opcode comes from bits 14 to 10
// RULE11 - Codes 0,1,3: move, load group, call
// RULE12 - Code 2 store group chosen by form
// RULE13 - Codes 4-6 flags move, input, output
// RULE14 - Codes 8-15 add through compare
// RULE15 - Codes 16-26 logic, bit, shift ops
// RULE16 - Codes 27-31 multiply through conditional flow
// RULE17 - Bit 15 selects literal or register
// RULE18 - Source 11111 means long immediate
// RULE19 - Spare opcodes, reserved codes flagged illegal
// RULE20 - Second word consumed, counter advanced
module risc_operand_decoder
    import risc_dec_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Instruction words from fetch
    input wire logic [15:0] instr_word,
    input wire logic word_valid,
    output logic word_ready,
    output logic ic_advance,
    // Register file read data
    input wire logic [31:0] src_reg_value,
    input wire logic [15:0] stack_pointer_reg,
    // Register selects
    output logic [4:0] src_sel,
    output logic src_is_pair,
    output logic [4:0] dst_sel,
    output logic dst_is_pair,
    // Decoded instruction
    output logic dec_valid,
    output logic [4:0] op_code,
    output addr_mode_t addr_mode,
    output mem_var_t mem_variant,
    output logic [31:0] operand,
    output logic [15:0] mem_addr,
    output logic [31:0] write_mask,
    output logic illegal
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        dec_state_t st;         // Sequencer state
        logic mbit;             // Literal select of the held word
        logic [4:0] opc;        // Held opcode
        logic [4:0] src_code;   // Held source field
        logic [4:0] dst_code;   // Held destination field
        logic [4:0] src_idx;    // Register file source select
        logic src_pair;
        logic src_rsv;
        logic [4:0] dst_idx;    // Register file destination select
        logic dst_pair;
        logic [15:0] imm;       // Second word
        logic ready;
        logic adv;              // One pulse per consumed word
        logic valid;
        logic bad;
        addr_mode_t am;
        mem_var_t mv;
        logic [31:0] opnd;
        logic [15:0] maddr;
        logic [31:0] wmask;
    } dec_regs_t;

    dec_regs_t q_r;   // Registered state
    dec_regs_t q_nxt; // Next state

    // Field maps of the incoming word
    logic [4:0] in_src_idx;
    logic in_src_pair;
    logic in_src_rsv;
    logic [4:0] in_dst_idx;
    logic in_dst_pair;

    reg_field_map u_src_map (
        .code(instr_word[SRC_HI:SRC_LO]),
        .is_dest(1'b0),
        .reg_idx(in_src_idx),
        .is_pair(in_src_pair),
        .reserved(in_src_rsv)
    );

    reg_field_map u_dst_map (
        .code(instr_word[DST_HI:DST_LO]),
        .is_dest(1'b1),
        .reg_idx(in_dst_idx),
        .is_pair(in_dst_pair),
        .reserved()
    );

    // Word handshake as seen on this edge
    logic take;
    assign take = word_valid && q_r.ready;

    // ==========================================================
    // Next-state logic
    // ==========================================================
    // Decoding waits for the register file answer, so every decode costs
    // one cycle after the last word; fetch sees that as ready going low.
    always_comb begin
        logic mem_op;
        logic [31:0] ext;
        logic dst_long;
        logic byte_op;
        mem_op = 1'b0;
        ext = 32'h0000_0000;
        dst_long = 1'b0;
        byte_op = 1'b0;
        q_nxt = q_r;
        q_nxt.adv = take;                                          // [RULE20]
        q_nxt.valid = 1'b0;
        case (q_r.st)
            ST_IDLE: begin
                if (take) begin
                    q_nxt.mbit = instr_word[MODE_BIT];             // [RULE17]
                    q_nxt.opc = instr_word[OPC_HI:OPC_LO];         // [RULE10]
                    q_nxt.src_code = instr_word[SRC_HI:SRC_LO];
                    q_nxt.dst_code = instr_word[DST_HI:DST_LO];
                    q_nxt.src_idx = in_src_idx;                    // [RULE2]
                    q_nxt.src_pair = in_src_pair;
                    q_nxt.src_rsv = in_src_rsv;
                    q_nxt.dst_idx = in_dst_idx;
                    q_nxt.dst_pair = in_dst_pair;
                    q_nxt.imm = 16'h0000;
                    // Register source 11111 always carries a second word
                    if (!instr_word[MODE_BIT]
                            && instr_word[SRC_HI:SRC_LO] == CODE_LONG) begin
                        q_nxt.st = ST_EXT;                         // [RULE18]
                    end else begin
                        q_nxt.st = ST_SIZE;
                        q_nxt.ready = 1'b0;
                    end
                end
            end
            ST_EXT: begin
                if (take) begin
                    q_nxt.imm = instr_word;                        // [RULE4]
                    q_nxt.st = ST_SIZE;
                    q_nxt.ready = 1'b0;
                end
            end
            ST_SIZE: begin
                mem_op = (q_r.opc == LOAD_GROUP_OP) || (q_r.opc == STORE_GROUP_OP);
                q_nxt.bad = (q_r.opc == SPARE_LOW_OP)
                    || (q_r.opc == SPARE_HIGH_OP);                 // [RULE19]
                q_nxt.mv = MV_NONE;
                q_nxt.maddr = 16'h0000;
                // Addressing form
                if (q_r.mbit) begin
                    q_nxt.am = AM_LIT;
                    ext = {{27{q_r.src_code[4]}}, q_r.src_code};   // [RULE5] [RULE8]
                    if (mem_op) begin
                        q_nxt.mv = MV_INSTR;                       // [RULE11] [RULE12]
                    end
                end else if (q_r.src_code == CODE_LONG) begin
                    if (mem_op || q_r.opc == port_input_op || q_r.opc == port_output_op) begin
                        q_nxt.am = AM_ABS;                         // [RULE4]
                        q_nxt.maddr = q_r.imm;
                        q_nxt.mv = mem_op ? MV_DATA : MV_NONE;
                    end else begin
                        q_nxt.am = AM_LONG;                        // [RULE18]
                        ext = {{16{q_r.imm[15]}}, q_r.imm};
                    end
                end else if (q_r.src_rsv) begin
                    q_nxt.am = AM_SP_IND;                          // [RULE3]
                    q_nxt.maddr = stack_pointer_reg;
                    q_nxt.mv = MV_STACK;                           // [RULE12]
                    q_nxt.bad = q_nxt.bad || !mem_op;              // [RULE19]
                end else if (mem_op || q_r.opc == port_input_op) begin
                    q_nxt.am = AM_REG_IND;                         // [RULE1]
                    q_nxt.maddr = src_reg_value[15:0];
                    q_nxt.mv = MV_DATA;
                end else begin
                    q_nxt.am = AM_REG;
                    // Pairs pass whole, single registers widen by sign
                    ext = q_r.src_pair ? src_reg_value
                        : {{16{src_reg_value[15]}}, src_reg_value[15:0]}; // [RULE7] [RULE8]
                end
                // Destination width and byte-only writes
                dst_long = q_r.dst_pair;
                byte_op = (q_r.opc == byte_add_op) || (q_r.opc == byte_subtract_op)
                    || (q_r.opc == byte_move_op);                  // [RULE14] [RULE16]
                q_nxt.opnd = dst_long ? ext : (ext & MASK_WORD);   // [RULE6] [RULE7]
                if (q_nxt.bad || q_r.dst_code == CODE_RSV) begin
                    q_nxt.wmask = MASK_NONE;                       // [RULE19]
                end else if (byte_op) begin
                    q_nxt.wmask = MASK_BYTE;                       // [RULE9]
                end else if (dst_long) begin
                    q_nxt.wmask = MASK_LONG;                       // [RULE8]
                end else begin
                    q_nxt.wmask = MASK_WORD;                       // [RULE5] [RULE6]
                end
                q_nxt.valid = 1'b1;
                q_nxt.ready = 1'b1;
                q_nxt.st = ST_IDLE;
            end
            default: begin
                q_nxt.st = ST_IDLE;
                q_nxt.ready = 1'b1;
            end
        endcase
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q_r <= '0;
            q_r.st <= ST_IDLE;
            q_r.ready <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    // ==========================================================
    // Outputs, all straight from the state register
    // ==========================================================
    // Opcodes 0..31 are presented as is; the execution side keys on the
    // named codes in the package for move, load, store and the rest.
    assign word_ready = q_r.ready;
    assign ic_advance = q_r.adv;
    assign src_sel = q_r.src_idx;
    assign src_is_pair = q_r.src_pair;
    assign dst_sel = q_r.dst_idx;
    assign dst_is_pair = q_r.dst_pair;
    assign dec_valid = q_r.valid;
    assign op_code = q_r.opc;                                      // [RULE13] [RULE15]
    assign addr_mode = q_r.am;
    assign mem_variant = q_r.mv;
    assign operand = q_r.opnd;
    assign mem_addr = q_r.maddr;
    assign write_mask = q_r.wmask;
    assign illegal = q_r.bad;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_long_word;
        take && q_r.st == ST_IDLE && !instr_word[MODE_BIT]
            && instr_word[SRC_HI:SRC_LO] == CODE_LONG;
    endsequence

    a_long_takes_two: assert property ( // [RULE20]
        s_long_word |=> (q_r.st == ST_EXT && ic_advance && word_ready))
        else $error("long form did not wait for second word");

    a_opcode_field: assert property ( // [RULE10]
        (take && q_r.st == ST_IDLE && (instr_word[15] || instr_word[4:0] != 5'h1f))
            |=> ##1 (dec_valid && op_code == $past(instr_word[14:10], 2)))
        else $error("opcode not taken from bits 14 to 10");

    a_spare_illegal: assert property ( // [RULE19]
        (dec_valid && (op_code == 5'h07 || op_code == 5'h17))
            |-> (illegal && write_mask == 32'h0000_0000))
        else $error("spare opcode not flagged");

    a_byte_mask: assert property ( // [RULE9]
        (dec_valid && !illegal && (op_code == 5'h0a || op_code == 5'h0e || op_code == 5'h1c)
            && q_r.dst_code != CODE_RSV) |-> (write_mask == 32'h0000_00ff))
        else $error("byte operation wrote more than eight bits");

    a_word_trunc: assert property ( // [RULE6]
        (dec_valid && !dst_is_pair) |-> (operand[31:16] == 16'h0000))
        else $error("word destination got upper half");

    a_lit_extend: assert property ( // [RULE8]
        (dec_valid && addr_mode == AM_LIT && dst_is_pair)
            |-> (operand[31:5] == {27{operand[4]}}))
        else $error("literal not sign extended");

    a_stack_only: assert property ( // [RULE3]
        (dec_valid && addr_mode == AM_SP_IND && !illegal)
            |-> (mem_variant == MV_STACK && (op_code == 5'h01 || op_code == 5'h02)))
        else $error("stack form outside pop and push");

    a_abs_addr: assert property ( // [RULE4]
        (q_r.st == ST_EXT && take) |=> ##1 (dec_valid
            && (addr_mode == AM_LONG || mem_addr == $past(instr_word, 2))))
        else $error("absolute address not from second word");

    a_ind_ops: assert property ( // [RULE1]
        (dec_valid && addr_mode == AM_REG_IND)
            |-> (op_code == 5'h01 || op_code == 5'h02 || op_code == 5'h05))
        else $error("register indirect on other opcode");

    a_ready_back: assert property ( // [RULE20]
        (dec_valid) |-> (word_ready && q_r.st == ST_IDLE))
        else $error("decoder not ready after decode");

endmodule

// ### rtl/risc_dec_pkg.sv
// Package: field layout, opcodes, mode codes and masks for the instruction decoder
package risc_dec_pkg;

    // ==========================================================
    // Instruction word fields
    // ==========================================================
    localparam int MODE_BIT = 15;   // Literal / register select
    localparam int OPC_HI = 14;     // Operation code field
    localparam int OPC_LO = 10;
    localparam int DST_HI = 9;      // Destination field
    localparam int DST_LO = 5;
    localparam int SRC_HI = 4;      // Source field
    localparam int SRC_LO = 0;

    // ==========================================================
    // Special field codes
    // ==========================================================
    localparam logic [4:0] CODE_LONG = 5'h1f;   // Long immediate / accumulator
    localparam logic [4:0] CODE_RSV = 5'h17;    // Reserved source, null destination
    localparam logic [4:0] ACC_SEL = 5'h14;     // Register file index of accumulator

    // ==========================================================
    // Operation codes
    // ==========================================================
    localparam logic [4:0] register_move_op = 5'h00;
    localparam logic [4:0] LOAD_GROUP_OP = 5'h01;
    localparam logic [4:0] STORE_GROUP_OP = 5'h02;
    localparam logic [4:0] CALL_OP = 5'h03;
    localparam logic [4:0] move_set_flags_op = 5'h04;
    localparam logic [4:0] port_input_op = 5'h05;
    localparam logic [4:0] port_output_op = 5'h06;
    localparam logic [4:0] SPARE_LOW_OP = 5'h07;
    localparam logic [4:0] ADD_OP = 5'h08;
    localparam logic [4:0] add_carry_op = 5'h09;
    localparam logic [4:0] byte_add_op = 5'h0a;
    localparam logic [4:0] unsigned_add_op = 5'h0b;
    localparam logic [4:0] SUBTRACT_OP = 5'h0c;
    localparam logic [4:0] subtract_borrow_op = 5'h0d;
    localparam logic [4:0] byte_subtract_op = 5'h0e;
    localparam logic [4:0] compare_op = 5'h0f;
    localparam logic [4:0] AND_OP = 5'h10;
    localparam logic [4:0] OR_OP = 5'h11;
    localparam logic [4:0] XOR_OP = 5'h12;
    localparam logic [4:0] NOT_OP = 5'h13;
    localparam logic [4:0] bit_clear_op = 5'h14;
    localparam logic [4:0] bit_set_op = 5'h15;
    localparam logic [4:0] bit_test_op = 5'h16;
    localparam logic [4:0] SPARE_HIGH_OP = 5'h17;
    localparam logic [4:0] logical_shift_op = 5'h18;
    localparam logic [4:0] arith_shift_op = 5'h19;
    localparam logic [4:0] cyclic_shift_op = 5'h1a;
    localparam logic [4:0] signed_multiply_op = 5'h1b;
    localparam logic [4:0] byte_move_op = 5'h1c;
    localparam logic [4:0] byte_swap_op = 5'h1d;
    localparam logic [4:0] signed_divide_op = 5'h1e;
    localparam logic [4:0] COND_FLOW_OP = 5'h1f;   // Jump (register) or branch (literal)

    // ==========================================================
    // Write masks for the register file
    // ==========================================================
    localparam logic [31:0] MASK_BYTE = 32'h0000_00ff;
    localparam logic [31:0] MASK_WORD = 32'h0000_ffff;
    localparam logic [31:0] MASK_LONG = 32'hffff_ffff;
    localparam logic [31:0] MASK_NONE = 32'h0000_0000;

    // ==========================================================
    // Enumerations
    // ==========================================================
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,   // Waiting for an opcode word
        ST_EXT = 2'b01,    // Waiting for the second word
        ST_SIZE = 2'b10    // Register file answered, size the operand
    } dec_state_t;

    typedef enum logic [2:0] {
        AM_REG = 3'b000,
        AM_LIT = 3'b001,
        AM_LONG = 3'b010,
        AM_REG_IND = 3'b011,
        AM_SP_IND = 3'b100,
        AM_ABS = 3'b101
    } addr_mode_t;

    typedef enum logic [1:0] {
        MV_NONE = 2'b00,
        MV_DATA = 2'b01,
        MV_INSTR = 2'b10,
        MV_STACK = 2'b11
    } mem_var_t;

endpackage

// ### rtl/reg_field_map.sv
// Maps a 5-bit register field onto a register file index and pair flag
`timescale 1ns/1ns
module reg_field_map
    import risc_dec_pkg::*;
(
    // Field in
    input wire logic [4:0] code,
    input wire logic is_dest,
    // Mapping out
    output logic [4:0] reg_idx,
    output logic is_pair,
    output logic reserved
);

    // ==========================================================
    // Field decode
    // ==========================================================
    // Codes below 10000 are the sixteen single registers
    always_comb begin
        reg_idx = code;
        is_pair = 1'b0;
        reserved = 1'b0;
        if (!code[4]) begin
            reg_idx = code;
        end else begin
            case (code)
                5'h11: reg_idx = 5'h10;   // R16
                5'h13: reg_idx = 5'h11;   // R17
                5'h19: reg_idx = 5'h12;   // R18
                5'h1b: reg_idx = 5'h13;   // R19
                5'h15: begin              // XR16
                    reg_idx = 5'h10;
                    is_pair = 1'b1;
                end
                5'h1d: begin              // XR18
                    reg_idx = 5'h12;
                    is_pair = 1'b1;
                end
                5'h17: begin              // Reserved source, null destination
                    reg_idx = 5'h00;
                    reserved = ~is_dest;
                end
                5'h1f: begin              // Long immediate source, accumulator dest
                    reg_idx = is_dest ? ACC_SEL : 5'h00;
                    is_pair = is_dest;
                    reserved = ~is_dest;
                end
                default: begin            // Even pairs XR0..XR14
                    reg_idx = {1'b0, code[3:0]};
                    is_pair = 1'b1;
                end
            endcase
        end
    end

endmodule

// ### verif/reg_file_model.sv
// Register file and stack pointer model facing the decoder's read ports
`timescale 1ns/1ns
module reg_file_model (
    // Register selects from the decoder
    input wire logic [4:0] src_sel,
    input wire logic src_is_pair,
    // Read data back to the decoder
    output logic [31:0] src_reg_value,
    output logic [15:0] stack_pointer_reg
);
    // ==========================================================
    // Combinational read
    // ==========================================================
    // Singles carry junk in the upper half to catch a decoder that keeps it
    always_comb begin
        if (src_is_pair) begin
            src_reg_value = 32'h1234_8a5c;
        end else begin
            src_reg_value = {16'h5a5a, 16'hf0a0 ^ {11'h000, src_sel}};
        end
    end

    // Stack pointer holds one fixed address
    assign stack_pointer_reg = 16'h7e3c;
endmodule

// ### verif/risc_operand_and_opcode_decoder_tb.sv
// Self-checking testbench for the instruction decoder
`timescale 1ns/1ns
module risc_operand_and_opcode_decoder_tb;
    import risc_dec_pkg::*;
    // ==========================================================
    // Signals
    // ==========================================================
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] instr_word = 16'h0000;
    logic word_valid = 1'b0;
    logic word_ready, ic_advance, src_is_pair, dst_is_pair, dec_valid, illegal;
    logic [4:0] src_sel, dst_sel, op_code;
    addr_mode_t addr_mode;
    mem_var_t mem_variant;
    logic [31:0] operand, write_mask, src_reg_value;
    logic [15:0] mem_addr, stack_pointer_reg;
    int err_total = 0;
    int total_checks = 0;
    int adv_cnt = 0; // Fetch advances seen so far

    // Clock, 50 ns period
    always #25 ref_clk = ~ref_clk;

    risc_operand_decoder DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .instr_word(instr_word),
        .word_valid(word_valid), .word_ready(word_ready), .ic_advance(ic_advance),
        .src_reg_value(src_reg_value), .stack_pointer_reg(stack_pointer_reg),
        .src_sel(src_sel), .src_is_pair(src_is_pair), .dst_sel(dst_sel),
        .dst_is_pair(dst_is_pair), .dec_valid(dec_valid), .op_code(op_code),
        .addr_mode(addr_mode), .mem_variant(mem_variant), .operand(operand),
        .mem_addr(mem_addr), .write_mask(write_mask), .illegal(illegal));

    reg_file_model rf (.src_sel(src_sel), .src_is_pair(src_is_pair),
        .src_reg_value(src_reg_value), .stack_pointer_reg(stack_pointer_reg));

    // Count advance pulses, which must match the words consumed
    always @(posedge ref_clk) begin
        if (ic_advance === 1'b1) adv_cnt <= adv_cnt + 1;
    end

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    function automatic logic [15:0] iw(input logic m, input logic [4:0] op,
        input logic [4:0] dst, input logic [4:0] src);
        return {m, op, dst, src};
    endfunction

    // Offer one word from a falling edge and hold it until the taking edge
    task automatic offer(input logic [15:0] w);
        int n;
        n = 0;
        @(negedge ref_clk);
        instr_word = w;
        word_valid = 1'b1;
        while (word_ready !== 1'b1 && n < 8) begin
            @(negedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
    endtask

    // Send one instruction, optionally with its second word, and wait for the result
    task automatic run(input logic [15:0] w, input bit two, input logic [15:0] w2);
        int n;
        int base;
        n = 0;
        base = adv_cnt;
        offer(w);
        if (two) offer(w2);
        @(negedge ref_clk);
        word_valid = 1'b0;
        while (dec_valid !== 1'b1 && n < 6) begin
            @(negedge ref_clk);
            n++;
        end
        chk_val("dec_valid", 32'(1'b1), 32'(dec_valid));
        chk_val("advances", two ? 32'h2 : 32'h1, 32'(adv_cnt - base));
    endtask

    task automatic expect_dec(input logic [2:0] am, input logic [1:0] mv,
        input logic [31:0] opnd, input logic [15:0] addr, input logic [31:0] mask);
        chk_val("addr_mode", 32'(am), 32'(addr_mode));
        chk_val("mem_variant", 32'(mv), 32'(mem_variant));
        chk_val("operand", opnd, operand);
        chk_val("mem_addr", 32'(addr), 32'(mem_addr));
        chk_val("write_mask", mask, write_mask);
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    // Reset holds four cycles; fetch side must see the decoder ready
    task automatic t_reset();
        repeat (4) @(negedge ref_clk);
        chk_val("word_ready", 32'(1'b1), 32'(word_ready));
        chk_val("dec_valid", 32'(1'b0), 32'(dec_valid));
        sys_rst = 1'b0;
    endtask

    // Operand sizing for every pairing of source and destination widths
    task automatic t_sizes();
        run(iw(1'b0, register_move_op, 5'h03, 5'h05), 1'b0, 16'h0000);
        expect_dec(AM_REG, MV_NONE, 32'h0000_f0a5, 16'h0000, MASK_WORD);
        chk_val("src_sel", 32'h5, 32'(src_sel));
        chk_val("dst_sel", 32'h3, 32'(dst_sel));
        run(iw(1'b1, ADD_OP, 5'h03, 5'h13), 1'b0, 16'h0000);
        expect_dec(AM_LIT, MV_NONE, 32'h0000_fff3, 16'h0000, MASK_WORD);
        run(iw(1'b1, ADD_OP, 5'h10, 5'h13), 1'b0, 16'h0000);
        expect_dec(AM_LIT, MV_NONE, 32'hffff_fff3, 16'h0000, MASK_LONG);
        chk_val("dst_is_pair", 32'(1'b1), 32'(dst_is_pair));
        run(iw(1'b0, ADD_OP, 5'h10, 5'h05), 1'b0, 16'h0000);
        expect_dec(AM_REG, MV_NONE, 32'hffff_f0a5, 16'h0000, MASK_LONG);
        run(iw(1'b0, ADD_OP, 5'h03, 5'h12), 1'b0, 16'h0000);
        expect_dec(AM_REG, MV_NONE, 32'h0000_8a5c, 16'h0000, MASK_WORD);
        chk_val("src_is_pair", 32'(1'b1), 32'(src_is_pair));
        run(iw(1'b0, ADD_OP, 5'h10, 5'h12), 1'b0, 16'h0000);
        expect_dec(AM_REG, MV_NONE, 32'h1234_8a5c, 16'h0000, MASK_LONG);
        run(iw(1'b0, byte_add_op, 5'h10, 5'h12), 1'b0, 16'h0000);
        chk_val("write_mask", MASK_BYTE, write_mask);
        run(iw(1'b1, byte_subtract_op, 5'h03, 5'h01), 1'b0, 16'h0000);
        chk_val("write_mask", MASK_BYTE, write_mask);
        run(iw(1'b0, byte_move_op, 5'h10, 5'h05), 1'b0, 16'h0000);
        chk_val("write_mask", MASK_BYTE, write_mask);
    endtask

    // Register and stack pointer indirect forms, allowed and refused
    task automatic t_indirect();
        run(iw(1'b0, LOAD_GROUP_OP, 5'h03, 5'h04), 1'b0, 16'h0000);
        expect_dec(AM_REG_IND, MV_DATA, 32'h0, 16'hf0a4, MASK_WORD);
        run(iw(1'b0, STORE_GROUP_OP, 5'h03, 5'h04), 1'b0, 16'h0000);
        chk_val("addr_mode", 32'(AM_REG_IND), 32'(addr_mode));
        chk_val("mem_variant", 32'(MV_DATA), 32'(mem_variant));
        run(iw(1'b0, port_input_op, 5'h03, 5'h04), 1'b0, 16'h0000);
        chk_val("mem_addr", 32'hf0a4, 32'(mem_addr));
        run(iw(1'b0, port_output_op, 5'h03, 5'h04), 1'b0, 16'h0000);
        chk_val("addr_mode", 32'(AM_REG), 32'(addr_mode));
        run(iw(1'b0, LOAD_GROUP_OP, 5'h03, 5'h17), 1'b0, 16'h0000);
        expect_dec(AM_SP_IND, MV_STACK, 32'h0, 16'h7e3c, MASK_WORD);
        run(iw(1'b0, STORE_GROUP_OP, 5'h03, 5'h17), 1'b0, 16'h0000);
        chk_val("mem_variant", 32'(MV_STACK), 32'(mem_variant));
        run(iw(1'b1, STORE_GROUP_OP, 5'h03, 5'h02), 1'b0, 16'h0000);
        chk_val("mem_variant", 32'(MV_INSTR), 32'(mem_variant));
        run(iw(1'b0, ADD_OP, 5'h03, 5'h17), 1'b0, 16'h0000);
        chk_val("illegal", 32'(1'b1), 32'(illegal));
        chk_val("write_mask", MASK_NONE, write_mask);
    endtask

    // Second-word forms: absolute address and long immediate
    task automatic t_two_word();
        run(iw(1'b0, LOAD_GROUP_OP, 5'h03, CODE_LONG), 1'b1, 16'h4c21);
        expect_dec(AM_ABS, MV_DATA, 32'h0, 16'h4c21, MASK_WORD);
        run(iw(1'b0, port_output_op, 5'h03, CODE_LONG), 1'b1, 16'h0333);
        chk_val("mem_addr", 32'h0333, 32'(mem_addr));
        chk_val("addr_mode", 32'(AM_ABS), 32'(addr_mode));
        run(iw(1'b0, ADD_OP, 5'h03, CODE_LONG), 1'b1, 16'h8001);
        expect_dec(AM_LONG, MV_NONE, 32'h0000_8001, 16'h0000, MASK_WORD);
        run(iw(1'b0, ADD_OP, CODE_LONG, CODE_LONG), 1'b1, 16'h8001);
        expect_dec(AM_LONG, MV_NONE, 32'hffff_8001, 16'h0000, MASK_LONG);
        chk_val("dst_sel", 32'h14, 32'(dst_sel));
    endtask

    // Every opcode decodes from bits 14 to 10; only the two spares are illegal
    task automatic t_opcodes();
        logic spare;
        for (int i = 0; i < 32; i++) begin
            spare = (i == 7) || (i == 23);
            run(iw(1'b1, 5'(i), 5'h03, 5'h02), 1'b0, 16'h0000);
            chk_val("op_code", 32'(i), 32'(op_code));
            chk_val("illegal", 32'(spare), 32'(illegal));
        end
    endtask

    // ==========================================================
    // Main sequence and watchdog
    // ==========================================================
    initial begin
        t_reset();
        t_sizes();
        t_indirect();
        t_two_word();
        t_opcodes();
        tally_and_finish();
    end

    // Whole run needs well under 1000 cycles; a hang is cut off at 5000
    initial begin
        #250000;
        err_total++;
        tally_and_finish();
    end
endmodule
